// ==== hdl/eacm_consts.vh ====
// Constants for the energy accumulation mode controller
`ifndef EACM_CONSTS_VH
`define EACM_CONSTS_VH

// ****************************************
// Widths
// ****************************************
`define EACM_SMP_W       16
`define EACM_VOLT_W      17
`define EACM_PWR_W       34
`define EACM_THR_W       48
`define EACM_ACC_W       49
`define EACM_ENERGY_W    32
`define EACM_CNT_W       16
`define EACM_REG_W       16

// ****************************************
// Accumulation mode register fields
// ****************************************
`define EACM_CONNECTION_SELECT_HI   5
`define EACM_CONNECTION_SELECT_LO   4
`define EACM_WACC_HI     1
`define EACM_WACC_LO     0
`define EACM_CONNECTION_SELECT_OWN  2'h0
`define EACM_CONNECTION_SELECT_3W   2'h1
`define EACM_CONNECTION_SELECT_WYE  2'h2
`define EACM_CONNECTION_SELECT_4D   2'h3
`define EACM_WACC_SIGNED 2'h0
`define EACM_WACC_ABS    2'h1

// ****************************************
// Line-cycle mode register fields
// ****************************************
`define EACM_LINE_CYCLE_ENERGY_ENABLE_BIT   0
`define EACM_ZERO_CROSS_PHASE_SELECT_HI    5
`define EACM_ZERO_CROSS_PHASE_SELECT_LO    3
`define EACM_RDCLR_BIT   6

// ****************************************
// Status, reset values
// ****************************************
`define EACM_LINE_ENERGY_DONE_FLAG_BIT 5
`define EACM_ENERGY_RST  32'h00000000
`define EACM_CNT_RST     16'h0000

`endif

// ==== hdl/eacm_thr_stage.v ====
// First accumulation stage: power to signed threshold pulses
`timescale 1ns/100ps
`include "eacm_consts.vh"
module eacm_thr_stage (
    // Clock and reset
    input  wire                          clk_sys_i,
    input  wire                          rst_n_i,
    // Power samples
    input  wire                          tick_i,
    input  wire signed [`EACM_PWR_W-1:0] power_i,
    input  wire        [`EACM_THR_W-1:0] threshold_i,
    // Energy quanta
    output reg                           pulse_o,
    output reg                           neg_o
);
    reg  signed [`EACM_ACC_W-1:0] acc_q;
    wire signed [`EACM_ACC_W-1:0] sum;
    wire signed [`EACM_ACC_W-1:0] thr;

    // Sign extension keeps negative power subtracting from the sum
    assign sum = acc_q + {{(`EACM_ACC_W-`EACM_PWR_W){power_i[`EACM_PWR_W-1]}}, power_i};
    assign thr = {1'b0, threshold_i};

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q   <= {`EACM_ACC_W{1'b0}};
            pulse_o <= 1'b0;
            neg_o   <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                if (thr != {`EACM_ACC_W{1'b0}} && sum >= thr) begin
                    acc_q   <= sum - thr;
                    pulse_o <= 1'b1;
                    neg_o   <= 1'b0;
                end else if (thr != {`EACM_ACC_W{1'b0}} && sum <= -thr) begin
                    acc_q   <= sum + thr;
                    pulse_o <= 1'b1;
                    neg_o   <= 1'b1;
                end else begin
                    acc_q <= sum;
                end
            end
        end
    end
endmodule

// ==== hdl/eacm_zx_counter.v ====
// Free-running half line cycle counter over selected zero crossings
`timescale 1ns/100ps
`include "eacm_consts.vh"
module eacm_zx_counter (
    // Clock and reset
    input  wire                   clk_sys_i,
    input  wire                   rst_n_i,
    // Crossings and selection
    input  wire [2:0]             zx_i,
    input  wire [2:0]             zx_sel_i,
    // Target and restart
    input  wire [`EACM_CNT_W-1:0] target_i,
    input  wire                   restart_i,
    // Period end
    output reg                    done_o
);
    reg  [`EACM_CNT_W-1:0] cnt_q;
    wire [2:0]             hit;
    wire [`EACM_CNT_W:0]   nxt;
    wire [1:0]             inc;

    assign hit = zx_i & zx_sel_i;
    assign inc = {1'b0, hit[0]} + {1'b0, hit[1]} + {1'b0, hit[2]};
    assign nxt = {1'b0, cnt_q} + {{(`EACM_CNT_W-1){1'b0}}, inc};

    // A zero target never ends a period; the counter keeps counting anyway
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= `EACM_CNT_RST;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (restart_i) begin
                cnt_q <= `EACM_CNT_RST;
            end else if (target_i != `EACM_CNT_RST &&
                         nxt >= {1'b0, target_i}) begin
                cnt_q  <= `EACM_CNT_RST;
                done_o <= 1'b1;
            end else begin
                cnt_q <= nxt[`EACM_CNT_W-1:0];
            end
        end
    end
endmodule

// ==== hdl/eacm_ctrl.v ====
// Energy accumulation mode controller: phase power, watt-hour sums, line-cycle mode
`timescale 1ns/100ps
`include "eacm_consts.vh"
module eacm_ctrl (
    // Clock and reset
    input  wire                             clk_sys_i,
    input  wire                             rst_n_i,
    // Mode registers written by the host
    input  wire [`EACM_REG_W-1:0]           accumulation_mode_reg_i,
    input  wire [`EACM_REG_W-1:0]           line_cycle_mode_reg_i,
    input  wire [`EACM_CNT_W-1:0]           half_cycle_count_i,
    input  wire                             half_cycle_count_wr_i,
    input  wire [`EACM_THR_W-1:0]           energy_threshold_i,
    // Status and interrupt mask
    input  wire                             status_reg_0_wr_i,
    input  wire [`EACM_REG_W-1:0]           status_reg_0_wdata_i,
    input  wire [`EACM_REG_W-1:0]           interrupt_mask_0_i,
    // Samples and accumulation tick
    input  wire                             sample_tick_i,
    input  wire signed [`EACM_SMP_W-1:0]    volt_a_i,
    input  wire signed [`EACM_SMP_W-1:0]    volt_b_i,
    input  wire signed [`EACM_SMP_W-1:0]    volt_c_i,
    input  wire signed [`EACM_SMP_W-1:0]    curr_a_i,
    input  wire signed [`EACM_SMP_W-1:0]    curr_b_i,
    input  wire signed [`EACM_SMP_W-1:0]    curr_c_i,
    // Voltage zero crossings, one-cycle pulses, bit 0 phase A
    input  wire [2:0]                       zero_cross_i,
    // Energy result reads, bit 0 phase A
    input  wire [2:0]                       energy_rd_i,
    // Energy results
    output wire [`EACM_ENERGY_W-1:0]        phase_a_total_energy_o,
    output wire [`EACM_ENERGY_W-1:0]        phase_b_total_energy_o,
    output wire [`EACM_ENERGY_W-1:0]        phase_c_total_energy_o,
    // Voltage fed to the phase-B rms engine
    output reg  signed [`EACM_VOLT_W-1:0]   phase_b_voltage_rms_src_o,
    // Quanta toward the pulse outputs, bit 0 phase A
    output reg  [2:0]                       pulse_quanta_o,
    output reg  [2:0]                       pulse_quanta_neg_o,
    // Status and interrupt
    output wire [`EACM_REG_W-1:0]           status_reg_0_o,
    output wire                             interrupt_request_n_o
);

    // ****************************************
    // Register field decode
    // ****************************************
    wire [1:0] connection_select;
    wire [1:0] pulse_accum_sign_mode;
    wire       line_cycle_energy_enable;
    wire       clear_on_read_enable;
    wire [2:0] zero_cross_phase_select;

    assign connection_select = accumulation_mode_reg_i[`EACM_CONNECTION_SELECT_HI:`EACM_CONNECTION_SELECT_LO];
    assign pulse_accum_sign_mode = accumulation_mode_reg_i[`EACM_WACC_HI:`EACM_WACC_LO];
    assign line_cycle_energy_enable = line_cycle_mode_reg_i[`EACM_LINE_CYCLE_ENERGY_ENABLE_BIT];
    assign clear_on_read_enable = line_cycle_mode_reg_i[`EACM_RDCLR_BIT];
    assign zero_cross_phase_select = line_cycle_mode_reg_i[`EACM_ZERO_CROSS_PHASE_SELECT_HI:`EACM_ZERO_CROSS_PHASE_SELECT_LO];

    // ****************************************
    // Helpers
    // ****************************************
    function signed [`EACM_VOLT_W-1:0] vext;
        input signed [`EACM_SMP_W-1:0] v;
        begin
            vext = {v[`EACM_SMP_W-1], v};
        end
    endfunction

    // Volts by amps, widened so a 17-bit synthesised voltage never overflows
    function signed [`EACM_PWR_W-1:0] vmul;
        input signed [`EACM_VOLT_W-1:0] v;
        input signed [`EACM_SMP_W-1:0]  i;
        reg   signed [`EACM_VOLT_W+`EACM_SMP_W-1:0] p;
        begin
            p    = v * i;
            vmul = {p[`EACM_VOLT_W+`EACM_SMP_W-1], p};
        end
    endfunction

    // ****************************************
    // Phase-B voltage substitution
    // ****************************************
    reg signed [`EACM_VOLT_W-1:0] volt_b_eff;

    always @* begin
        case (connection_select)
            `EACM_CONNECTION_SELECT_OWN: volt_b_eff = vext(volt_b_i);
            `EACM_CONNECTION_SELECT_3W:  volt_b_eff = vext(volt_a_i) - vext(volt_c_i);
            `EACM_CONNECTION_SELECT_WYE: volt_b_eff = -vext(volt_a_i) - vext(volt_c_i);
            `EACM_CONNECTION_SELECT_4D:  volt_b_eff = -vext(volt_a_i);
            default:          volt_b_eff = vext(volt_b_i);
        endcase
    end

    // Rms engine sees the A-to-C line voltage in three-wire service
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_b_voltage_rms_src_o <= {`EACM_VOLT_W{1'b0}};
        end else if (sample_tick_i) begin
            if (connection_select == `EACM_CONNECTION_SELECT_3W) begin
                phase_b_voltage_rms_src_o <= vext(volt_a_i) - vext(volt_c_i);
            end else begin
                phase_b_voltage_rms_src_o <= vext(volt_b_i);
            end
        end
    end

    // ****************************************
    // Phase power and first stage
    // ****************************************
    wire signed [`EACM_PWR_W-1:0] power_a;
    wire signed [`EACM_PWR_W-1:0] power_b;
    wire signed [`EACM_PWR_W-1:0] power_c;
    wire [2:0]                    quantum;
    wire [2:0]                    quantum_neg;

    assign power_a = vmul(vext(volt_a_i), curr_a_i);
    assign power_b = vmul(volt_b_eff, curr_b_i);
    assign power_c = vmul(vext(volt_c_i), curr_c_i);

    eacm_thr_stage u_thr_a (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .tick_i      (sample_tick_i),
        .power_i     (power_a),
        .threshold_i (energy_threshold_i),
        .pulse_o     (quantum[0]),
        .neg_o       (quantum_neg[0])
    );

    eacm_thr_stage u_thr_b (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .tick_i      (sample_tick_i),
        .power_i     (power_b),
        .threshold_i (energy_threshold_i),
        .pulse_o     (quantum[1]),
        .neg_o       (quantum_neg[1])
    );

    eacm_thr_stage u_thr_c (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .tick_i      (sample_tick_i),
        .power_i     (power_c),
        .threshold_i (energy_threshold_i),
        .pulse_o     (quantum[2]),
        .neg_o       (quantum_neg[2])
    );

    // ****************************************
    // Pulse output sign mode
    // ****************************************
    // Absolute mode only folds the sign toward the pulse outputs; the
    // watt-hour sums below never see this and stay signed
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_quanta_o     <= 3'h0;
            pulse_quanta_neg_o <= 3'h0;
        end else begin
            pulse_quanta_o <= quantum;
            if (pulse_accum_sign_mode == `EACM_WACC_ABS) begin
                pulse_quanta_neg_o <= 3'h0;
            end else begin
                pulse_quanta_neg_o <= quantum & quantum_neg;
            end
        end
    end

    // ****************************************
    // Half line cycle counting
    // ****************************************
    wire period_done;
    wire count_restart;

    // Restart is only meaningful while the mode is on; otherwise it free-runs
    assign count_restart = half_cycle_count_wr_i & line_cycle_energy_enable;

    eacm_zx_counter u_zx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .zx_i      (zero_cross_i),
        .zx_sel_i  (zero_cross_phase_select),
        .target_i  (half_cycle_count_i),
        .restart_i (count_restart),
        .done_o    (period_done)
    );

    // ****************************************
    // Second stage: signed watt-hour sums
    // ****************************************
    reg  [`EACM_ENERGY_W-1:0] accum_q  [0:2];
    reg  [`EACM_ENERGY_W-1:0] result_q [0:2];
    reg  [`EACM_ENERGY_W-1:0] step     [0:2];
    reg  [`EACM_ENERGY_W-1:0] accum_nx [0:2];
    wire                      lc_transfer;
    integer                   k;
    integer                   j;

    assign lc_transfer = line_cycle_energy_enable & period_done;

    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            if (!quantum[k]) begin
                step[k] = `EACM_ENERGY_RST;
            end else if (quantum_neg[k]) begin
                step[k] = {`EACM_ENERGY_W{1'b1}};
            end else begin
                step[k] = {{(`EACM_ENERGY_W-1){1'b0}}, 1'b1};
            end
            // Wraps at full scale in both directions, as a signed counter must
            accum_nx[k] = accum_q[k] + step[k];
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (j = 0; j < 3; j = j + 1) begin
                accum_q[j]  <= `EACM_ENERGY_RST;
                result_q[j] <= `EACM_ENERGY_RST;
            end
        end else begin
            for (j = 0; j < 3; j = j + 1) begin
                if (line_cycle_energy_enable) begin
                    // Same quanta and weight as normal mode, only the moment differs
                    if (lc_transfer) begin
                        result_q[j] <= accum_nx[j];
                        accum_q[j]  <= `EACM_ENERGY_RST;
                    end else begin
                        accum_q[j] <= accum_nx[j];
                    end
                end else if (energy_rd_i[j] && clear_on_read_enable) begin
                    // A quantum landing in the read cycle is kept, not dropped
                    accum_q[j]  <= step[j];
                    result_q[j] <= step[j];
                end else begin
                    accum_q[j]  <= accum_nx[j];
                    result_q[j] <= accum_nx[j];
                end
            end
        end
    end

    assign phase_a_total_energy_o = result_q[0];
    assign phase_b_total_energy_o = result_q[1];
    assign phase_c_total_energy_o = result_q[2];

    // ****************************************
    // Status flag and interrupt
    // ****************************************
    reg  line_energy_done_flag_q;
    wire flag_clear;

    assign flag_clear = status_reg_0_wr_i & status_reg_0_wdata_i[`EACM_LINE_ENERGY_DONE_FLAG_BIT];

    // Set wins over a clear arriving in the same cycle
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_energy_done_flag_q <= 1'b0;
        end else if (lc_transfer) begin
            line_energy_done_flag_q <= 1'b1;
        end else if (flag_clear) begin
            line_energy_done_flag_q <= 1'b0;
        end
    end

    assign status_reg_0_o = {{(`EACM_REG_W-`EACM_LINE_ENERGY_DONE_FLAG_BIT-1){1'b0}},
                             line_energy_done_flag_q,
                             {`EACM_LINE_ENERGY_DONE_FLAG_BIT{1'b0}}};
    assign interrupt_request_n_o = ~(line_energy_done_flag_q &
                                     interrupt_mask_0_i[`EACM_LINE_ENERGY_DONE_FLAG_BIT]);

endmodule

// ==== dv/eacm_ctrl_asserts.sv ====
// Concurrent checks on the energy accumulation mode controller ports
`timescale 1ns/100ps
`include "eacm_consts.vh"
module eacm_ctrl_asserts (
    // Clock and reset
    input wire logic                             clk_sys_i,
    input wire logic                             rst_n_i,
    // Observed inputs
    input wire logic        [`EACM_REG_W-1:0]    accumulation_mode_reg_i,
    input wire logic        [`EACM_REG_W-1:0]    line_cycle_mode_reg_i,
    input wire logic                             status_reg_0_wr_i,
    input wire logic        [`EACM_REG_W-1:0]    status_reg_0_wdata_i,
    input wire logic        [`EACM_REG_W-1:0]    interrupt_mask_0_i,
    input wire logic                             sample_tick_i,
    input wire logic signed [`EACM_SMP_W-1:0]    volt_a_i,
    input wire logic signed [`EACM_SMP_W-1:0]    volt_b_i,
    input wire logic signed [`EACM_SMP_W-1:0]    volt_c_i,
    input wire logic        [2:0]                energy_rd_i,
    // Observed outputs
    input wire logic        [`EACM_ENERGY_W-1:0] phase_a_total_energy_o,
    input wire logic signed [`EACM_VOLT_W-1:0]   phase_b_voltage_rms_src_o,
    input wire logic        [2:0]                pulse_quanta_o,
    input wire logic        [2:0]                pulse_quanta_neg_o,
    input wire logic        [`EACM_REG_W-1:0]    status_reg_0_o,
    input wire logic                             interrupt_request_n_o
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    wire       flag = status_reg_0_o[`EACM_LINE_ENERGY_DONE_FLAG_BIT];
    wire       lc_on = line_cycle_mode_reg_i[`EACM_LINE_CYCLE_ENERGY_ENABLE_BIT];
    wire [1:0] smode = accumulation_mode_reg_i[`EACM_WACC_HI:`EACM_WACC_LO];
    wire [1:0] csel = accumulation_mode_reg_i[`EACM_CONNECTION_SELECT_HI:`EACM_CONNECTION_SELECT_LO];
    chk_rms_source: assert property (
        sample_tick_i |=> phase_b_voltage_rms_src_o == (($past(csel) == `EACM_CONNECTION_SELECT_3W) ?
        $past(volt_a_i) - $past(volt_c_i) : $past(volt_b_i))) else $error("rms source wrong");
    chk_abs_no_negative: assert property (
        smode == `EACM_WACC_ABS && $past(smode) == `EACM_WACC_ABS &&
        $past(smode, 2) == `EACM_WACC_ABS |-> pulse_quanta_neg_o == 3'h0) else $error("abs sign");
    chk_irq_follows_flag: assert property (
        interrupt_request_n_o == !(flag && interrupt_mask_0_i[`EACM_LINE_ENERGY_DONE_FLAG_BIT]))
        else $error("interrupt level wrong");
    chk_flag_holds: assert property (
        flag && !(status_reg_0_wr_i && status_reg_0_wdata_i[`EACM_LINE_ENERGY_DONE_FLAG_BIT]) |=> flag)
        else $error("flag lost without clear");
    chk_flag_clears: assert property (
        $fell(flag) |-> $past(status_reg_0_wr_i && status_reg_0_wdata_i[`EACM_LINE_ENERGY_DONE_FLAG_BIT]))
        else $error("flag fell without clear");
    chk_quanta_cause: assert property (
        |pulse_quanta_o |-> $past(sample_tick_i, 2)) else $error("quantum without tick");
    chk_lc_holds_result: assert property (
        lc_on && $past(lc_on) && $changed(phase_a_total_energy_o) |-> flag)
        else $error("result moved mid-period");
    chk_normal_step: assert property (
        !lc_on && $past(!lc_on) && $past(!lc_on, 2) && !$past(energy_rd_i[0]) &&
        $changed(phase_a_total_energy_o)
        |-> (phase_a_total_energy_o - $past(phase_a_total_energy_o) == 32'h1) ||
        ($past(phase_a_total_energy_o) - phase_a_total_energy_o == 32'h1)) else $error("step");
    chk_read_clears: assert property (
        energy_rd_i[0] && line_cycle_mode_reg_i[`EACM_RDCLR_BIT] && !lc_on |=>
        phase_a_total_energy_o inside {32'h0, 32'h1, 32'hFFFFFFFF}) else $error("no clear");
    cover property ($rose(flag));
    cover property (|pulse_quanta_neg_o);
    cover property (sample_tick_i && csel == `EACM_CONNECTION_SELECT_3W);
    cover property (energy_rd_i[0] && line_cycle_mode_reg_i[`EACM_RDCLR_BIT]);
endmodule

bind eacm_ctrl eacm_ctrl_asserts chk_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_tick_i(sample_tick_i),
    .accumulation_mode_reg_i(accumulation_mode_reg_i), .energy_rd_i(energy_rd_i),
    .line_cycle_mode_reg_i(line_cycle_mode_reg_i), .status_reg_0_wr_i(status_reg_0_wr_i),
    .status_reg_0_wdata_i(status_reg_0_wdata_i), .interrupt_mask_0_i(interrupt_mask_0_i),
    .volt_a_i(volt_a_i), .volt_b_i(volt_b_i), .volt_c_i(volt_c_i),
    .phase_a_total_energy_o(phase_a_total_energy_o), .pulse_quanta_o(pulse_quanta_o),
    .phase_b_voltage_rms_src_o(phase_b_voltage_rms_src_o), .status_reg_0_o(status_reg_0_o),
    .pulse_quanta_neg_o(pulse_quanta_neg_o), .interrupt_request_n_o(interrupt_request_n_o)
);

// ==== dv/eacm_ctrl_test.sv ====
// Self-checking bench for the energy accumulation mode controller
`timescale 1ns/100ps
`include "eacm_consts.vh"
module eacm_ctrl_test;
    reg                clk_sys_i = 1'b0;
    reg                rst_n_i   = 1'b0;
    reg         [15:0] acc_mode  = 16'h0000;
    reg         [15:0] lc_mode   = 16'h0000;
    reg         [15:0] hc_count  = 16'h0000;
    reg                hc_wr     = 1'b0;
    reg         [47:0] thr       = 48'h000001000000;
    reg                st_wr     = 1'b0;
    reg         [15:0] st_wdata  = 16'h0000;
    reg         [15:0] mask      = 16'h0000;
    reg                tick      = 1'b0;
    reg  signed [15:0] v[3]      = '{default: 16'h0000};
    reg  signed [15:0] cur[3]    = '{default: 16'h0000};
    reg         [2:0]  zx        = 3'h0;
    reg         [2:0]  rd        = 3'h0;
    wire        [31:0] res[3];
    wire signed [16:0] rms_src;
    wire        [2:0]  q;
    wire        [2:0]  qn;
    wire        [15:0] st;
    wire               irq_n;
    integer            errors    = 0;
    integer            n_tests   = 0;
    integer            seed      = 32'h4a64;
    integer            n;
    integer            cnt;
    longint            acc1[3]   = '{default: 0};
    longint            model[3]  = '{default: 0};
    longint            lc_acc[3] = '{default: 0};

    eacm_ctrl dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .accumulation_mode_reg_i(acc_mode),
        .line_cycle_mode_reg_i(lc_mode), .half_cycle_count_i(hc_count),
        .half_cycle_count_wr_i(hc_wr), .energy_threshold_i(thr), .status_reg_0_wr_i(st_wr),
        .status_reg_0_wdata_i(st_wdata), .interrupt_mask_0_i(mask), .sample_tick_i(tick),
        .volt_a_i(v[0]), .volt_b_i(v[1]), .volt_c_i(v[2]),
        .curr_a_i(cur[0]), .curr_b_i(cur[1]), .curr_c_i(cur[2]),
        .zero_cross_i(zx), .energy_rd_i(rd), .phase_a_total_energy_o(res[0]),
        .phase_b_total_energy_o(res[1]), .phase_c_total_energy_o(res[2]),
        .phase_b_voltage_rms_src_o(rms_src), .pulse_quanta_o(q), .pulse_quanta_neg_o(qn),
        .status_reg_0_o(st), .interrupt_request_n_o(irq_n)
    );

    always #12.5 clk_sys_i = ~clk_sys_i;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    // One sample: the bench keeps its own first stage so residues carry across ticks
    task automatic do_tick;
        longint     p;
        longint     vb;
        longint     t;
        int         qk;
        int         k;
        logic [1:0] sel;
        logic signed [16:0] e;
        for (k = 0; k < 3; k++) begin
            v[k] = $random(seed) % 16384;
            cur[k] = $random(seed);
        end
        zx = $random(seed) & ~lc_mode[5:3];
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        zx = 3'h0;
        step(1);
        sel = acc_mode[5:4];
        t = thr;
        vb = (sel == 2'h0) ? v[1] : (sel == 2'h1) ? v[0] - v[2] :
             (sel == 2'h2) ? -v[0] - v[2] : -v[0];
        e = (sel == `EACM_CONNECTION_SELECT_3W) ? vb : v[1];
        check(rms_src, e, "rms source");
        for (k = 0; k < 3; k++) begin
            p = (k == 1) ? vb * cur[1] : v[k] * cur[k];
            acc1[k] += p;
            qk = (acc1[k] >= t) ? 1 : (acc1[k] <= -t) ? -1 : 0;
            acc1[k] -= qk * t;
            if (lc_mode[0])
                lc_acc[k] += qk;
            else
                model[k] += qk;
            check(q[k], qk != 0, "quantum");
            check(qn[k], qk < 0 && acc_mode[1:0] != `EACM_WACC_ABS, "quantum sign");
            check(res[k], model[k][31:0], "energy");
        end
    endtask

    task automatic read_all;
        step(1);
        rd = 3'h7;
        step(1);
        rd = 3'h0;
        if (lc_mode[6])
            model = '{default: 0};
        for (int k = 0; k < 3; k++)
            check(res[k], model[k][31:0], "read");
    endtask

    task automatic st_write(input logic [15:0] d);
        st_wr = 1'b1;
        st_wdata = d;
        step(1);
        st_wr = 1'b0;
        // Let an edge pass so back-to-back writes never re-raise the strobe at once
        step(1);
    endtask

    task end_of_test;
        $display("errors = %0d, n_tests = %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        errors = errors + 1;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        thr = 48'h000001000000 + {$random(seed)} % 32'h04000000;
        repeat (16) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        check({st, irq_n}, 17'h00001, "reset state");
        // Normal mode; no phase is selected, so crossings leave the free counter still with no target
        for (n = 0; n < 200; n++) begin
            acc_mode = $random(seed) & 16'h0033;
            lc_mode[6] = $random(seed);
            do_tick;
            if (n % 16 == 0)
                read_all;
        end
        lc_mode[6] = 1'b1;
        read_all;
        // Line-cycle mode, clear-on-read kept low, random phase mix for three periods, then phase C only
        lc_mode = 16'h0001 | (({$random(seed)} % 7 + 1) << 3);
        step(1);
        for (n = 0; n < 6; n++) begin
            if (n == 3)
                lc_mode[5:3] = 3'h4;
            hc_count = (n == 0) ? 16'h0001 : 16'h0001 + {$random(seed)} % 5;
            hc_wr = 1'b1;
            mask = $random(seed);
            step(1);
            hc_wr = 1'b0;
            repeat (3) do_tick;
            cnt = 0;
            while (cnt < hc_count) begin
                zx = $random(seed);
                cnt = cnt + $countones(zx & lc_mode[5:3]);
                step(1);
            end
            zx = 3'h0;
            check(st[5], 1'b0, "early flag");
            step(1);
            for (cnt = 0; cnt < 3; cnt++) begin
                model[cnt] = lc_acc[cnt];
                lc_acc[cnt] = 0;
                check(res[cnt], model[cnt][31:0], "period energy");
            end
            check(st, 16'h0020, "period flag");
            check(irq_n, !mask[5], "irq level");
            st_write(16'hFFDF & $random(seed));
            check(st[5], 1'b1, "flag kept");
            st_write(16'h0020);
            check({st[5], irq_n}, 2'b01, "flag cleared");
        end
        end_of_test;
    end
endmodule
